// [common/dsd_pkg.sv]
// ****************************************
// data space decoder constants
// ****************************************
package dsd_pkg;
  // region sizes in bytes
  localparam int REG_COUNT = 32;
  localparam int IO_COUNT = 64;
  localparam int XIO_COUNT = 160;
  localparam int SRAM_NORM_COUNT = 4096;
  localparam int SRAM_COMPAT_COUNT = 4000;
  // region bases derived from the sizes
  localparam logic [15:0] IO_BASE = 16'(REG_COUNT);
  localparam logic [15:0] XIO_BASE = 16'(REG_COUNT + IO_COUNT);
  localparam logic [15:0] SRAM_BASE_NORM = 16'(REG_COUNT + IO_COUNT + XIO_COUNT);
  localparam logic [15:0] SRAM_BASE_COMPAT = XIO_BASE;
  localparam logic [15:0] EXT_BASE_NORM = 16'(REG_COUNT + IO_COUNT + XIO_COUNT + SRAM_NORM_COUNT);
  localparam logic [15:0] EXT_BASE_COMPAT = 16'(REG_COUNT + IO_COUNT + SRAM_COMPAT_COUNT);
  localparam logic [5:0] IO_PORT_MASK = 6'h3F;
  // own registers in the standard i/o region
  localparam logic [15:0] MCU_CTRL_ADDR = 16'h0055;
  localparam logic [15:0] NV_CTRL_ADDR = 16'h003C;
  localparam logic [15:0] NV_DATA_ADDR = 16'h003D;
  localparam logic [15:0] NV_ADDR_LO_ADDR = 16'h003E;
  localparam logic [15:0] NV_ADDR_HI_ADDR = 16'h003F;
  // mcu control fields
  localparam int MCU_EXT_EN_BIT = 7;
  localparam int MCU_WS_LSB = 2;
  localparam logic [7:0] MCU_CTRL_MASK = 8'h8C;
  localparam logic [7:0] MCU_CTRL_RESET = 8'h00;
  // nonvolatile control fields
  localparam int NV_RD_BIT = 0;
  localparam int NV_WSTB_BIT = 1;
  localparam int NV_ARM_BIT = 2;
  localparam int NV_RIE_BIT = 3;
  localparam logic [1:0] NV_SEL_CTRL = 2'h0;
  localparam logic [1:0] NV_SEL_DATA = 2'h1;
  localparam logic [1:0] NV_SEL_LO = 2'h2;
  localparam logic [1:0] NV_SEL_HI = 2'h3;
  // timing in clock cycles, clock period and write time in ns
  localparam int INT_ACCESS_CYC = 2;
  localparam int EXT_BYTE_EXTRA = 1;
  localparam int PC_PAIR_EXTRA = 3;
  localparam int NV_ARM_CYC = 4;
  localparam int NV_RD_STALL = 4;
  localparam int NV_WR_STALL = 2;
  localparam int CLK_PERIOD_NS = 100;
  localparam int NV_WRITE_TIME_NS = 8500000;
  localparam int NV_WRITE_CYC = NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  // access targets
  typedef enum logic [2:0] {TGT_NONE, TGT_REGS, TGT_IO, TGT_XIO, TGT_SRAM, TGT_EXT} dsd_target_t;
endpackage : dsd_pkg

// [verilog/dsd_access_timer.sv]
`timescale 1ns/10ps
// ****************************************
// per-access cycle counter
// ****************************************
module dsd_access_timer
  import dsd_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // access start
  input wire logic start,
  input wire logic ext_access,
  input wire logic pc_pair,
  input wire logic [1:0] wait_states,
  // status
  output logic busy,
  output logic done,
  output logic stall
);
  typedef enum logic {ST_IDLE, ST_BUSY} dsd_tstate_t;
  dsd_tstate_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  generate
    if (CNT_W < 4) begin : g_chk
      $error("counter too narrow for nine extra cycles");
    end
  endgenerate

  // extra cycles: byte 1+ws, pc pair 3+2ws, internal none
  always_comb begin
    nxt_cnt = CNT_W'(INT_ACCESS_CYC - 2);
    if (ext_access && pc_pair) begin
      nxt_cnt = CNT_W'(INT_ACCESS_CYC - 2 + PC_PAIR_EXTRA) + CNT_W'({wait_states, 1'b0});
    end else if (ext_access) begin
      nxt_cnt = CNT_W'(INT_ACCESS_CYC - 2 + EXT_BYTE_EXTRA) + CNT_W'(wait_states);
    end
  end

  // state and count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_BUSY;
            cnt_ff <= nxt_cnt;
          end
        end
        ST_BUSY: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_IDLE; // internal access ends in its second cycle
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  assign busy = (state_ff == ST_BUSY);
  assign done = busy && (cnt_ff == '0);
  assign stall = busy && (cnt_ff != '0);
endmodule : dsd_access_timer

// [verilog/dsd_nv_port.sv]
`timescale 1ns/10ps
// ****************************************
// nonvolatile byte memory port
// ****************************************
module dsd_nv_port
  import dsd_pkg::*;
#(
  parameter int AW = 12,
  parameter int DEPTH = 4096,
  parameter int WRITE_CYC = NV_WRITE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register access
  input wire logic reg_we,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // status
  output logic stall,
  output logic write_busy,
  output logic ready_irq
);
  localparam int WCW = $clog2(WRITE_CYC + 1);
  logic [7:0] mem_ff [DEPTH];
  logic [AW-1:0] addr_ff;
  logic [7:0] data_ff;
  logic arm_ff;
  logic [2:0] arm_cnt_ff;
  logic wstb_ff;
  logic rie_ff;
  logic [WCW-1:0] wr_cnt_ff;
  logic [2:0] stall_cnt_ff;
  logic ctrl_we;
  logic start_wr;
  logic start_rd;

  generate
    if (DEPTH != (1 << AW) || AW > 16 || WRITE_CYC < 1) begin : g_chk
      $error("bad nonvolatile port parameters");
    end
  endgenerate

  assign ctrl_we = reg_we && (reg_sel == NV_SEL_CTRL);
  assign start_wr = ctrl_we && reg_wdata[NV_WSTB_BIT] && arm_ff && !wstb_ff;
  assign start_rd = ctrl_we && reg_wdata[NV_RD_BIT] && !wstb_ff;

  // address and data registers; address frozen while writing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= '0;
      data_ff <= 8'h00;
    end else begin
      if (reg_we && reg_sel == NV_SEL_LO && !wstb_ff) begin
        addr_ff[7:0] <= reg_wdata;
      end
      if (reg_we && reg_sel == NV_SEL_HI && !wstb_ff) begin
        addr_ff[AW-1:8] <= reg_wdata[AW-9:0];
      end
      if (start_rd) begin
        data_ff <= mem_ff[addr_ff];
      end else if (reg_we && reg_sel == NV_SEL_DATA) begin
        data_ff <= reg_wdata;
      end
    end
  end

  // write arm, self-clears four cycles after set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arm_ff <= 1'b0;
      arm_cnt_ff <= 3'h0;
      rie_ff <= 1'b0;
    end else begin
      if (ctrl_we) begin
        rie_ff <= reg_wdata[NV_RIE_BIT];
      end
      if (ctrl_we && reg_wdata[NV_ARM_BIT] && !arm_ff) begin
        arm_ff <= 1'b1;
        arm_cnt_ff <= 3'(NV_ARM_CYC - 1);
      end else if (arm_ff && arm_cnt_ff == 3'h0) begin
        arm_ff <= 1'b0;
      end else if (arm_ff) begin
        arm_cnt_ff <= arm_cnt_ff - 3'h1;
      end
    end
  end

  // self-timed write, strobe clears at completion
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wstb_ff <= 1'b0;
      wr_cnt_ff <= '0;
    end else if (start_wr) begin
      wstb_ff <= 1'b1;
      wr_cnt_ff <= WCW'(WRITE_CYC - 1);
    end else if (wstb_ff && wr_cnt_ff == '0) begin
      wstb_ff <= 1'b0;
    end else if (wstb_ff) begin
      wr_cnt_ff <= wr_cnt_ff - 1'b1;
    end
  end

  // storage, written when the write time has elapsed
  always_ff @(posedge sys_clk) begin
    if (wstb_ff && wr_cnt_ff == '0) begin
      mem_ff[addr_ff] <= data_ff;
    end
  end

  // cpu stall after read or write start
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt_ff <= 3'h0;
    end else if (start_rd) begin
      stall_cnt_ff <= 3'(NV_RD_STALL);
    end else if (start_wr) begin
      stall_cnt_ff <= 3'(NV_WR_STALL);
    end else if (stall_cnt_ff != 3'h0) begin
      stall_cnt_ff <= stall_cnt_ff - 3'h1;
    end
  end

  // register read mux
  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_sel)
      NV_SEL_CTRL: reg_rdata = {4'h0, rie_ff, arm_ff, wstb_ff, 1'b0};
      NV_SEL_DATA: reg_rdata = data_ff;
      NV_SEL_LO: reg_rdata = addr_ff[7:0];
      NV_SEL_HI: reg_rdata = 8'(addr_ff[AW-1:8]);
    endcase
  end

  assign stall = (stall_cnt_ff != 3'h0);
  assign write_busy = wstb_ff;
  assign ready_irq = rie_ff && !wstb_ff;
endmodule : dsd_nv_port

// [verilog/dsd_decoder.sv]
`timescale 1ns/10ps

module dsd_decoder
  import dsd_pkg::*;
#(
  parameter int NV_AW = 12,
  parameter int NV_DEPTH = 4096,
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,

  // static mode strap
  input wire logic compat_mode,

  // cpu request
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_io_instr,
  input wire logic cpu_pc_pair,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,

  // cpu answer
  output logic cpu_ready,
  output logic cpu_stall,
  output logic [7:0] cpu_rdata_ff,

  // internal target side
  output logic tgt_active,
  output dsd_target_t tgt_ff,
  output logic [15:0] tgt_offset_ff,
  output logic tgt_we_ff,
  output logic [7:0] tgt_wdata_ff,
  input wire logic [7:0] tgt_rdata,

  // external sram pins
  output logic [15:0] ext_addr_ff,
  output logic [7:0] ext_wdata_ff,
  output logic ext_data_oe,
  input wire logic [7:0] ext_rdata,
  output logic ext_read_strobe_pin_n,
  output logic ext_write_strobe_pin_n,

  // status
  output logic ext_mem_enable,
  output logic nv_write_busy,
  output logic nv_ready_irq
);

  // decode
  logic [15:0] eff_addr;
  dsd_target_t nxt_tgt;

  // sequencing
  logic accept;
  logic busy;
  logic done;
  logic acc_stall;
  logic nv_stall;

  // control state
  logic [7:0] mcu_ctrl_ff;
  logic [1:0] wait_states;
  logic [15:0] lat_addr_ff;
  // strobe state
  logic ext_rd_ff;
  logic ext_wr_ff;

  // port hookup
  logic nv_we;
  logic [1:0] nv_sel;
  logic [1:0] nv_rd_sel;
  logic [7:0] nv_rdata;
  logic [7:0] own_rdata;

  // ****************************************
  // address decoding
  // ****************************************

  // region of a data address under the current mode
  function automatic dsd_target_t map_target(
    input logic [15:0] a,
    input logic compat,
    input logic ext_en
  );
    dsd_target_t t;
    t = TGT_NONE;
    if (a < IO_BASE) begin
      t = TGT_REGS;
    end else if (a < XIO_BASE) begin
      t = TGT_IO;
    end else if (!compat && a < SRAM_BASE_NORM) begin
      t = TGT_XIO;
    end else if (a < (compat ? EXT_BASE_COMPAT : EXT_BASE_NORM)) begin
      t = TGT_SRAM;
    end else if (ext_en) begin
      t = TGT_EXT;
    end
    return t;
  endfunction : map_target

  // first address of a region
  function automatic logic [15:0] region_base(
    input dsd_target_t t,
    input logic compat
  );
    logic [15:0] b;
    b = 16'h0000;
    unique case (t)
      TGT_IO: b = IO_BASE;
      TGT_XIO: b = XIO_BASE;
      TGT_SRAM: b = compat ? SRAM_BASE_COMPAT : SRAM_BASE_NORM;
      TGT_EXT: b = compat ? EXT_BASE_COMPAT : EXT_BASE_NORM;
      TGT_NONE, TGT_REGS: b = 16'h0000;
    endcase
    return b;
  endfunction : region_base

  // true when the address hits an own nonvolatile register
  function automatic logic nv_hit(input logic [15:0] a);
    return (a >= NV_CTRL_ADDR) && (a <= NV_ADDR_HI_ADDR);
  endfunction : nv_hit

  // i/o instructions carry a port number that only reaches standard i/o
  assign eff_addr = cpu_io_instr
    ? IO_BASE + {10'h000, cpu_addr[5:0] & IO_PORT_MASK}
    : cpu_addr;
  // region under the strap and enable
  assign nxt_tgt = map_target(eff_addr, compat_mode, ext_mem_enable);

  // ****************************************
  // access sequencing
  // ****************************************

  // taken only when idle and not stalled
  assign accept = cpu_req && !busy && !nv_stall;

  // extra cycles per target and wait states
  dsd_access_timer #(
    .CNT_W(4)
  ) u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(accept),
    .ext_access(nxt_tgt == TGT_EXT),
    .pc_pair(cpu_pc_pair),
    .wait_states(wait_states),
    .busy(busy),
    .done(done),
    .stall(acc_stall)
  );

  // handshake to the cpu
  assign cpu_ready = done;
  assign cpu_stall = acc_stall || nv_stall;
  assign tgt_active = busy;

  // latch the target side at acceptance
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tgt_ff <= TGT_NONE;
      tgt_offset_ff <= 16'h0000;
      tgt_we_ff <= 1'b0;
      tgt_wdata_ff <= 8'h00;
      lat_addr_ff <= 16'h0000;
    end else if (accept) begin
      tgt_ff <= nxt_tgt;
      // offset within the selected region
      tgt_offset_ff <= eff_addr - region_base(nxt_tgt, compat_mode);
      tgt_we_ff <= cpu_we;
      tgt_wdata_ff <= cpu_wdata;
      lat_addr_ff <= eff_addr;
    end
  end

  // ****************************************
  // external sram pins
  // ****************************************

  // strobes only for external targets, held until the access ends
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_rd_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
      ext_addr_ff <= 16'h0000;
      ext_wdata_ff <= 8'h00;
    end else if (accept && nxt_tgt == TGT_EXT) begin
      // loads use read, stores use write
      ext_rd_ff <= !cpu_we;
      ext_wr_ff <= cpu_we;
      ext_addr_ff <= eff_addr;
      ext_wdata_ff <= cpu_wdata;
    end else if (done) begin
      ext_rd_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
    end
  end

  // strobe pins are active low, ext_data_oe is active high
  assign ext_read_strobe_pin_n = !ext_rd_ff;
  assign ext_write_strobe_pin_n = !ext_wr_ff;
  assign ext_data_oe = ext_wr_ff;

  // ****************************************
  // own registers
  // ****************************************

  // mcu control: external enable and wait states
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mcu_ctrl_ff <= MCU_CTRL_RESET;
    end else if (accept && cpu_we && eff_addr == MCU_CTRL_ADDR) begin
      mcu_ctrl_ff <= cpu_wdata & MCU_CTRL_MASK;
    end
  end

  // mcu control fields
  assign ext_mem_enable = mcu_ctrl_ff[MCU_EXT_EN_BIT];
  assign wait_states = mcu_ctrl_ff[MCU_WS_LSB+1:MCU_WS_LSB];

  // nonvolatile register access through i/o space
  assign nv_we = accept && cpu_we && nv_hit(eff_addr);
  assign nv_sel = nv_we ? 2'(eff_addr - NV_CTRL_ADDR)
    : nv_rd_sel;
  assign nv_rd_sel = 2'(lat_addr_ff - NV_CTRL_ADDR);

  // port decodes the register index
  dsd_nv_port #(
    .AW(NV_AW),
    .DEPTH(NV_DEPTH),
    .WRITE_CYC(NV_WRITE_CYCLES)
  ) u_nv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .reg_we(nv_we),
    .reg_sel(nv_sel),
    .reg_wdata(cpu_wdata),
    .reg_rdata(nv_rdata),
    .stall(nv_stall),
    .write_busy(nv_write_busy),
    .ready_irq(nv_ready_irq)
  );

  // own register read value
  always_comb begin
    own_rdata = 8'h00;
    if (lat_addr_ff == MCU_CTRL_ADDR) begin
      own_rdata = mcu_ctrl_ff;
    end else if (nv_hit(lat_addr_ff)) begin
      // answer through the port mux
      own_rdata = nv_rdata;
    end
  end

  // ****************************************
  // read data return
  // ****************************************

  // captured in the last cycle of the access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_rdata_ff <= 8'h00;
    end else if (done && !tgt_we_ff) begin
      // own registers sit inside the i/o region
      if (lat_addr_ff == MCU_CTRL_ADDR || nv_hit(lat_addr_ff)) begin
        cpu_rdata_ff <= own_rdata;
      end else if (tgt_ff == TGT_EXT) begin
        cpu_rdata_ff <= ext_rdata;
      end else if (tgt_ff == TGT_NONE) begin
        // disabled external space reads zero
        cpu_rdata_ff <= 8'h00;
      end else begin
        cpu_rdata_ff <= tgt_rdata;
      end
    end
  end
endmodule : dsd_decoder

// [test/dsd_decoder_chk.sv]
`timescale 1ns/10ps
// ****************************************
// decoder port checker
// ****************************************
module dsd_decoder_chk
  import dsd_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // cpu side
  input wire logic compat_mode,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_io_instr,
  input wire logic cpu_pc_pair,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_ready,
  input wire logic cpu_stall,
  // target and pins
  input wire logic tgt_active,
  input wire dsd_target_t tgt_ff,
  input wire logic [15:0] tgt_offset_ff,
  input wire logic ext_read_strobe_pin_n,
  input wire logic ext_write_strobe_pin_n,
  input wire logic ext_mem_enable,
  input wire logic nv_write_busy
);
  logic take;
  logic is_ext;
  logic [15:0] dadr;
  logic [1:0] ws_ff;
  logic [3:0] lat_ff;
  int busy_cnt_ff;
  // request decode
  assign take = cpu_req && !tgt_active && !cpu_stall;
  assign dadr = cpu_io_instr ? (16'h0020 + {10'h000, cpu_addr[5:0]}) : cpu_addr;
  assign is_ext = !cpu_io_instr && (cpu_addr >= (compat_mode ? EXT_BASE_COMPAT : EXT_BASE_NORM));
  // shadow of wait states, expected answer countdown, busy length
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ws_ff <= 2'h0;
      lat_ff <= 4'h0;
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= nv_write_busy ? busy_cnt_ff + 1 : 0;
      if (take && cpu_we && dadr == MCU_CTRL_ADDR) begin
        ws_ff <= cpu_wdata[3:2];
      end
      if (take) begin
        lat_ff <= !(is_ext && ext_mem_enable) ? 4'h1 : cpu_pc_pair ? 4'(4 + 2 * ws_ff) : 4'(2 + ws_ff);
      end else if (lat_ff != 4'h0) begin
        lat_ff <= lat_ff - 4'h1;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence nv_read_go;
    take && cpu_we && dadr == NV_CTRL_ADDR && cpu_wdata[NV_RD_BIT] && !nv_write_busy;
  endsequence
  sequence halt_four;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  ready_timing_a: assert property (lat_ff != 4'h0 |-> cpu_ready == (lat_ff == 4'h1))
    else $error("access answer at wrong cycle");
  int_strobes_a: assert property (tgt_active && tgt_ff != TGT_EXT |-> ext_read_strobe_pin_n && ext_write_strobe_pin_n)
    else $error("strobe active on internal access");
  ext_gate_a: assert property (!(ext_read_strobe_pin_n && ext_write_strobe_pin_n) |-> ext_mem_enable && tgt_ff == TGT_EXT)
    else $error("strobe without enabled external access");
  xio_map_a: assert property (take && !cpu_io_instr && !compat_mode && cpu_addr inside {[16'h0060:16'h00FF]}
    |=> tgt_ff == TGT_XIO)
    else $error("extended io not selected");
  compat_xio_a: assert property (take && !cpu_io_instr && compat_mode && cpu_addr inside {[16'h0060:16'h00FF]}
    |=> tgt_ff == TGT_SRAM)
    else $error("compat mode decoded extended io");
  io_port_a: assert property (take && cpu_io_instr |=> tgt_ff == TGT_IO && tgt_offset_ff == ($past(cpu_addr) & 16'h003F))
    else $error("io instruction left standard io");
  ext_select_a: assert property (take && is_ext && ext_mem_enable |=> tgt_ff == TGT_EXT)
    else $error("external region not selected");
  read_halt_a: assert property (nv_read_go |=> halt_four)
    else $error("read stall not four cycles");
  write_halt_a: assert property ($rose(nv_write_busy) |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  write_time_a: assert property ($fell(nv_write_busy) |-> busy_cnt_ff == NV_WRITE_CYCLES)
    else $error("write busy length wrong");
endmodule : dsd_decoder_chk

bind dsd_decoder dsd_decoder_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_dsd_decoder_chk (
  .sys_clk(sys_clk), .nrst(nrst), .compat_mode(compat_mode), .cpu_req(cpu_req), .cpu_we(cpu_we),
  .cpu_io_instr(cpu_io_instr), .cpu_pc_pair(cpu_pc_pair), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .cpu_ready(cpu_ready), .cpu_stall(cpu_stall), .tgt_active(tgt_active), .tgt_ff(tgt_ff),
  .tgt_offset_ff(tgt_offset_ff), .ext_read_strobe_pin_n(ext_read_strobe_pin_n),
  .ext_write_strobe_pin_n(ext_write_strobe_pin_n), .ext_mem_enable(ext_mem_enable),
  .nv_write_busy(nv_write_busy));

// [test/dsd_ext_sram_model.sv]
`timescale 1ns/10ps
// ****************************************
// external sram model
// ****************************************
module dsd_ext_sram_model (
  // pins from the decoder
  input wire logic sys_clk,
  input wire logic [15:0] ext_addr_ff,
  input wire logic [7:0] ext_wdata_ff,
  input wire logic ext_data_oe,
  input wire logic ext_read_strobe_pin_n,
  input wire logic ext_write_strobe_pin_n,
  // read data
  output logic [7:0] ext_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // store while the write strobe is low, remember the last byte read
  always @(posedge sys_clk) begin
    if (!ext_write_strobe_pin_n && ext_data_oe) begin
      mem[ext_addr_ff] <= ext_wdata_ff;
    end
    if (!ext_read_strobe_pin_n) begin
      last <= ext_rdata;
    end
  end
  // released bus shows the inverse of the last byte
  assign ext_rdata = !ext_read_strobe_pin_n ? mem[ext_addr_ff] : ~last;
endmodule : dsd_ext_sram_model

// [test/dsd_decoder_bench.sv]
`timescale 1ns/10ps
// ****************************************
// decoder testbench
// ****************************************
module dsd_decoder_bench;
  import dsd_pkg::*;
  typedef struct {logic c; logic io; logic [15:0] a; dsd_target_t t; logic [15:0] off;} dsd_row_t;
  logic sys_clk, nrst, compat_mode, cpu_req, cpu_we, cpu_io_instr, cpu_pc_pair, tgt_we;
  logic [15:0] cpu_addr, tgt_offset_ff, ext_addr_ff;
  logic [7:0] cpu_wdata, cpu_rdata_ff, tgt_rdata, ext_wdata_ff, ext_rdata, tgt_wdata;
  logic cpu_ready, cpu_stall, tgt_active, ext_data_oe, rd_n, wr_n, ext_mem_enable, nv_write_busy, nv_ready_irq;
  dsd_target_t tgt_ff;
  int err_total = 0;
  int total_checks = 0;
  int lat;
  int n;
  dsd_row_t rows [12] = '{
    '{1'b0, 1'b0, 16'h0000, TGT_REGS, 16'h0000}, '{1'b0, 1'b0, 16'h001F, TGT_REGS, 16'h001F},
    '{1'b0, 1'b0, 16'h0020, TGT_IO, 16'h0000}, '{1'b0, 1'b0, 16'h005F, TGT_IO, 16'h003F},
    '{1'b0, 1'b0, 16'h0060, TGT_XIO, 16'h0000}, '{1'b0, 1'b0, 16'h00FF, TGT_XIO, 16'h009F},
    '{1'b0, 1'b0, 16'h0100, TGT_SRAM, 16'h0000}, '{1'b0, 1'b0, 16'h10FF, TGT_SRAM, 16'h0FFF},
    '{1'b0, 1'b1, 16'h00FF, TGT_IO, 16'h003F}, '{1'b1, 1'b0, 16'h005F, TGT_IO, 16'h003F},
    '{1'b1, 1'b0, 16'h0060, TGT_SRAM, 16'h0000}, '{1'b1, 1'b0, 16'h0FFF, TGT_SRAM, 16'h0F9F}};
  // internal targets answer with the inverted offset
  assign tgt_rdata = ~tgt_offset_ff[7:0];
  dsd_decoder #(.NV_WRITE_CYCLES(20)) u_dsd_decoder (
    .sys_clk(sys_clk), .nrst(nrst), .compat_mode(compat_mode), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_io_instr(cpu_io_instr), .cpu_pc_pair(cpu_pc_pair), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ready(cpu_ready), .cpu_stall(cpu_stall), .cpu_rdata_ff(cpu_rdata_ff), .tgt_active(tgt_active),
    .tgt_ff(tgt_ff), .tgt_offset_ff(tgt_offset_ff), .tgt_we_ff(tgt_we), .tgt_wdata_ff(tgt_wdata),
    .tgt_rdata(tgt_rdata),
    .ext_addr_ff(ext_addr_ff), .ext_wdata_ff(ext_wdata_ff), .ext_data_oe(ext_data_oe), .ext_rdata(ext_rdata),
    .ext_read_strobe_pin_n(rd_n), .ext_write_strobe_pin_n(wr_n), .ext_mem_enable(ext_mem_enable),
    .nv_write_busy(nv_write_busy), .nv_ready_irq(nv_ready_irq));
  dsd_ext_sram_model u_dsd_ext_sram_model (
    .sys_clk(sys_clk), .ext_addr_ff(ext_addr_ff), .ext_wdata_ff(ext_wdata_ff), .ext_data_oe(ext_data_oe),
    .ext_read_strobe_pin_n(rd_n), .ext_write_strobe_pin_n(wr_n), .ext_rdata(ext_rdata));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_lat(input int e);
    total_checks++;
    if (lat != e) begin
      err_total++;
      $display("unexpected latency: expected %0d seen %0d", e, lat);
    end
  endtask : chk_lat
  // one cpu access: hold the request until taken, then count to the answer
  task automatic acc(input logic we, input logic io, input logic pc, input logic [15:0] a, input logic [7:0] d);
    int w;
    w = 0;
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_io_instr <= io;
    cpu_pc_pair <= pc;
    cpu_addr <= a;
    cpu_wdata <= d;
    #1;
    while ((tgt_active || cpu_stall) && w < 60) begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    @(posedge sys_clk);
    cpu_req <= 1'b0;
    #1;
    lat = 1;
    while (!cpu_ready && lat < 20) begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    if (w >= 60 || lat >= 20) begin
      err_total++;
      summarize();
    end
    @(posedge sys_clk);
    #1;
  endtask : acc
  task automatic do_reset(input logic m);
    @(posedge sys_clk);
    nrst <= 1'b0;
    compat_mode <= m;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("target after reset", {13'h0, TGT_NONE}, {13'h0, tgt_ff});
    chk("strobes after reset", 16'h0003, {14'h0, rd_n, wr_n});
    acc(1'b0, 1'b0, 1'b0, MCU_CTRL_ADDR, 8'h00);
    chk("mcu control reset", {8'h00, MCU_CTRL_RESET}, {8'h00, cpu_rdata_ff});
    for (int i = 0; i < 12; i++) begin
      if (rows[i].c == m) begin
        acc(1'b0, rows[i].io, 1'b0, rows[i].a, 8'h00);
        chk("target", {13'h0, rows[i].t}, {13'h0, tgt_ff});
        chk("offset", rows[i].off, tgt_offset_ff);
        chk("load data", {8'h00, ~rows[i].off[7:0]}, {8'h00, cpu_rdata_ff});
        chk_lat(1);
      end
    end
    $display("map table done, mode %0d", m);
  endtask : do_reset
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {nrst, compat_mode, cpu_req, cpu_we, cpu_io_instr, cpu_pc_pair} = 6'h00;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    do_reset(1'b0);
    acc(1'b1, 1'b0, 1'b0, 16'h0200, 8'h3C);
    chk("store target", 16'h013C, {7'h0, tgt_we, tgt_wdata});
    acc(1'b0, 1'b0, 1'b0, 16'h2000, 8'h00);
    chk("disabled external load", 16'h0000, {8'h00, cpu_rdata_ff});
    for (int w = 0; w < 4; w++) begin
      acc(1'b1, 1'b0, 1'b0, MCU_CTRL_ADDR, 8'(8'h80 + 4 * w));
      acc(1'b1, 1'b0, 1'b0, 16'(16'h1100 + w), 8'(8'h5A + w));
      chk_lat(2 + w);
      acc(1'b0, 1'b0, 1'b0, 16'(16'h1100 + w), 8'h00);
      chk_lat(2 + w);
      chk("external load", 16'(8'h5A + w), {8'h00, cpu_rdata_ff});
      acc(1'b0, 1'b0, 1'b1, 16'hFF00, 8'h00);
      chk_lat(4 + 2 * w);
    end
    chk("ext enable", 16'h0001, {15'h0, ext_mem_enable});
    $display("external timing done");
    acc(1'b1, 1'b0, 1'b0, NV_ADDR_HI_ADDR, 8'hFF);
    acc(1'b0, 1'b0, 1'b0, NV_ADDR_HI_ADDR, 8'h00);
    chk("nv address high", 16'h000F, {8'h00, cpu_rdata_ff});
    acc(1'b1, 1'b0, 1'b0, NV_ADDR_HI_ADDR, 8'h00);
    acc(1'b1, 1'b0, 1'b0, NV_ADDR_LO_ADDR, 8'h34);
    acc(1'b1, 1'b0, 1'b0, NV_DATA_ADDR, 8'hA5);
    acc(1'b1, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h02);
    chk("strobe without arm", 16'h0000, {15'h0, nv_write_busy});
    acc(1'b1, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h04);
    repeat (6) @(posedge sys_clk);
    acc(1'b1, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h02);
    chk("strobe after arm expiry", 16'h0000, {15'h0, nv_write_busy});
    acc(1'b1, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h04);
    acc(1'b1, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h0A);
    chk("write started", 16'h0001, {15'h0, nv_write_busy});
    acc(1'b0, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h00);
    chk("control while busy", 16'h000A, {8'h00, cpu_rdata_ff});
    n = 0;
    while (cpu_rdata_ff[NV_WSTB_BIT] !== 1'b0 && n < 40) begin
      acc(1'b0, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h00);
      n++;
    end
    chk("write done", 16'h0000, {15'h0, nv_write_busy});
    chk("ready irq", 16'h0001, {15'h0, nv_ready_irq});
    acc(1'b1, 1'b0, 1'b0, NV_DATA_ADDR, 8'h00);
    acc(1'b1, 1'b0, 1'b0, NV_CTRL_ADDR, 8'h01);
    acc(1'b0, 1'b1, 1'b0, 16'h001D, 8'h00);
    chk("nv read back", 16'h00A5, {8'h00, cpu_rdata_ff});
    $display("nonvolatile port done");
    do_reset(1'b1);
    acc(1'b1, 1'b0, 1'b0, MCU_CTRL_ADDR, 8'h80);
    acc(1'b1, 1'b0, 1'b0, 16'h1000, 8'hC3);
    chk_lat(2);
    acc(1'b0, 1'b0, 1'b0, 16'h1000, 8'h00);
    chk("compat external load", 16'h00C3, {8'h00, cpu_rdata_ff});
    $display("compat external done");
    summarize();
  end
endmodule : dsd_decoder_bench
